// [core/cstpo_pkg.sv]
// Shared constants for the channel scaling and time-proportional output block
package cstpo_pkg;
   localparam int VAL_W = 16;
   localparam int MV_W = 10;
   localparam int PER_W = 7;
   localparam int TC_W = 14;
   localparam int DP_W = 2;
   localparam int NOUT = 4;
   // Reset values
   localparam logic signed [15:0] SCALE_HI_RST = 16'sh03e8;
   localparam logic signed [15:0] SCALE_LO_RST = 16'sh0000;
   localparam logic [1:0] DP_RST = 2'h1;
   localparam logic [13:0] FILT_TC_RST = 14'h0000;
   localparam logic [6:0] PERIOD_RST = 7'h02;
   // Settable ranges
   localparam logic signed [15:0] SCALE_MIN = -16'sd1999;
   localparam logic signed [15:0] SCALE_MAX = 16'sd9999;
   localparam logic [13:0] FILT_TC_MAX = 14'h270f;
   localparam logic [6:0] PERIOD_MAX = 7'h63;
   localparam logic [9:0] MV_FULL = 10'h3e8;
   // Timing
   localparam int CLK_KHZ = 25000;
   localparam int TICK_MS = 10;
   localparam int TICK_CYCLES = CLK_KHZ * TICK_MS;
   localparam int HALF_PERIOD_MS = 500;
   localparam int HALF_PERIOD_TICKS = HALF_PERIOD_MS / TICK_MS;
   localparam int SEC_TICKS = 1000 / TICK_MS;
   localparam int FILT_TC_MS = 100;
   localparam int FILT_FRAC = 8;
   localparam int MV_SCALE = 1000;
endpackage

// [core/cstpo_tp_out.sv]
// One time-proportional output with its own period counter
`timescale 1ns/10ps
`default_nettype none
module cstpo_tp_out
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic tick,
   input wire logic [6:0] period_set,
   input wire logic [9:0] mv,
   input wire logic force_off,
   output logic out_on
);
   typedef struct packed {
      logic [13:0] cnt;
      logic on;
   } cstpo_tp_t;

   cstpo_tp_t st_ff;
   cstpo_tp_t nxt_st;
   logic [13:0] len;
   logic [9:0] mv_c;
   logic [31:0] lhs;
   logic [31:0] rhs;

   always_comb
   begin
      nxt_st = st_ff;
      if (period_set == 7'h00)
      begin
         len = 14'(cstpo_pkg::HALF_PERIOD_TICKS);
      end
      else
      begin
         len = 14'(32'(period_set) * cstpo_pkg::SEC_TICKS);
      end
      mv_c = (mv > cstpo_pkg::MV_FULL) ? cstpo_pkg::MV_FULL : mv;
      // Cross-multiplied compare avoids a divider per output
      lhs = 32'(st_ff.cnt) * 32'(cstpo_pkg::MV_SCALE);
      rhs = 32'(mv_c) * 32'(len);
      if (tick)
      begin
         // A shortened period restarts the cycle rather than overrunning
         if (st_ff.cnt >= len - 14'h0001)
         begin
            nxt_st.cnt = 14'h0000;
         end
         else
         begin
            nxt_st.cnt = st_ff.cnt + 14'h0001;
         end
      end
      nxt_st.on = !force_off && (lhs < rhs);
   end

   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign out_on = st_ff.on;
endmodule // cstpo_tp_out
`default_nettype wire

// [core/cstpo_top.sv]
// Channel scaling, input filter and time-proportional outputs
// Functional notes
// - Scaling applies only for analog input types
// - Span top maps to upper limit
// - Span bottom maps to lower limit
// - Decimal point code gives fractional digits
// - Scaling writes only while operation stopped
// - Larger limit acts as upper limit
// - First-order lag filter, 0.0-999.9 s
// - ON fraction per period equals MV
// - Period per output, 0-99 s, default 2
// - Period setting zero gives 0.5 s
// - Two-channel unit: outputs 3,4 follow alarm 1
// - Comm error forces MV to zero
`timescale 1ns/10ps
`default_nettype none
module cstpo_top
#(
   parameter int RAW_W = 12,
   parameter int TICK_CYC = cstpo_pkg::TICK_CYCLES,
   parameter int SAMPLE_MS = 100
)
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic input_is_analog,
   input wire logic op_running,
   input wire logic signed [15:0] wr_data,
   input wire logic wr_scale_hi,
   input wire logic wr_scale_lo,
   input wire logic wr_dp,
   input wire logic wr_filt_tc,
   input wire logic [3:0] wr_period,
   input wire logic [RAW_W-1:0] raw_in,
   input wire logic raw_valid,
   input wire logic signed [15:0] temp_in,
   input wire logic [9:0] mv,
   input wire logic comm_err,
   input wire logic two_ch_unit,
   input wire logic [1:0] alarm1,
   output logic [3:0] ctrl_out,
   output logic signed [15:0] pv,
   output logic pv_valid,
   output logic [1:0] dp_digits,
   output logic signed [15:0] scale_hi,
   output logic signed [15:0] scale_lo,
   output logic [13:0] filt_tc,
   output logic comm_err_seen
);
   localparam logic [RAW_W-1:0] RAW_MAX = '1;

   if (RAW_W < 2 || RAW_W > 16)
   begin : g_chk_raw
      $error("RAW_W must be 2 to 16");
   end
   if (TICK_CYC < 1 || SAMPLE_MS < 1)
   begin : g_chk_time
      $error("TICK_CYC and SAMPLE_MS must be positive");
   end

   typedef struct packed {
      logic signed [15:0] hi;
      logic signed [15:0] lo;
      logic [1:0] dp;
      logic [13:0] tc;
      logic [3:0][6:0] per;
      logic signed [31:0] y;
      logic pv_vld;
      logic [2:0] err_sync;
      logic err;
      logic [31:0] tick_cnt;
      logic tick;
      logic [1:0] alm;
   } cstpo_st_t;

   cstpo_st_t st_ff;
   cstpo_st_t nxt_st;
   logic signed [31:0] hi_eff;
   logic signed [31:0] lo_eff;
   logic signed [47:0] prod;
   logic signed [31:0] scaled;
   logic signed [31:0] x_in;
   logic signed [47:0] diff;
   logic signed [47:0] den;
   logic signed [47:0] step;
   logic [3:0] tp_on;

   function automatic logic in_range(input logic signed [15:0] v);
      in_range = (v >= cstpo_pkg::SCALE_MIN) && (v <= cstpo_pkg::SCALE_MAX);
   endfunction

   always_comb
   begin
      nxt_st = st_ff;
      // Parameter writes; out-of-range limit, filter and period values are dropped, dp keeps the low 2 bits of any value
      if (!op_running)
      begin
         if (wr_scale_hi && in_range(wr_data))
         begin
            nxt_st.hi = wr_data;
         end
         if (wr_scale_lo && in_range(wr_data))
         begin
            nxt_st.lo = wr_data;
         end
         if (wr_dp)
         begin
            nxt_st.dp = wr_data[1:0];
         end
      end
      if (wr_filt_tc && wr_data >= 16'sh0000 && wr_data <= 16'(cstpo_pkg::FILT_TC_MAX))
      begin
         nxt_st.tc = wr_data[13:0];
      end
      for (int i = 0; i < cstpo_pkg::NOUT; i++)
      begin
         if (wr_period[i] && wr_data >= 16'sh0000 && wr_data <= 16'(cstpo_pkg::PERIOD_MAX))
         begin
            nxt_st.per[i] = wr_data[6:0];
         end
      end

      // Swapped limits: larger one is the top of the span
      if (st_ff.lo > st_ff.hi)
      begin
         hi_eff = 32'(st_ff.lo);
         lo_eff = 32'(st_ff.hi);
      end
      else
      begin
         hi_eff = 32'(st_ff.hi);
         lo_eff = 32'(st_ff.lo);
      end
      prod = 48'(hi_eff - lo_eff) * $signed({32'h0, 16'(raw_in)});
      scaled = lo_eff + 32'(prod / $signed(48'(RAW_MAX)));
      x_in = input_is_analog ? scaled : 32'(temp_in);

      // Lag filter: y += (x - y) * Ts / (tau + Ts)
      diff = 48'(x_in <<< cstpo_pkg::FILT_FRAC) - 48'(st_ff.y);
      den = 48'(32'(st_ff.tc) * cstpo_pkg::FILT_TC_MS + SAMPLE_MS);
      step = (diff * 48'(SAMPLE_MS)) / den;
      nxt_st.pv_vld = raw_valid;
      if (raw_valid)
      begin
         if (st_ff.tc == 14'h0000)
         begin
            nxt_st.y = x_in <<< cstpo_pkg::FILT_FRAC;
         end
         else
         begin
            nxt_st.y = st_ff.y + 32'(step);
         end
      end

      // Comm error is a foreign level: change taken when stages 2 and 3 agree
      nxt_st.err_sync = {st_ff.err_sync[1:0], comm_err};
      if (st_ff.err_sync[1] == st_ff.err_sync[2])
      begin
         nxt_st.err = st_ff.err_sync[2];
      end

      if (st_ff.tick_cnt >= 32'(TICK_CYC - 1))
      begin
         nxt_st.tick_cnt = 32'h0000_0000;
         nxt_st.tick = 1'b1;
      end
      else
      begin
         nxt_st.tick_cnt = st_ff.tick_cnt + 32'h0000_0001;
         nxt_st.tick = 1'b0;
      end
      nxt_st.alm = alarm1;
   end

   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         st_ff.hi <= cstpo_pkg::SCALE_HI_RST;
         st_ff.lo <= cstpo_pkg::SCALE_LO_RST;
         st_ff.dp <= cstpo_pkg::DP_RST;
         st_ff.tc <= cstpo_pkg::FILT_TC_RST;
         st_ff.per <= {cstpo_pkg::NOUT{cstpo_pkg::PERIOD_RST}};
         st_ff.y <= 32'h0000_0000;
         st_ff.pv_vld <= 1'b0;
         st_ff.err_sync <= 3'h0;
         st_ff.err <= 1'b0;
         st_ff.tick_cnt <= 32'h0000_0000;
         st_ff.tick <= 1'b0;
         st_ff.alm <= 2'h0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   for (genvar i = 0; i < cstpo_pkg::NOUT; i++)
   begin : g_out
      cstpo_tp_out u_tp
      (
         .clock(clock),
         .nrst(nrst),
         .tick(st_ff.tick),
         .period_set(st_ff.per[i]),
         .mv(mv),
         .force_off(st_ff.err),
         .out_on(tp_on[i])
      );
   end

   // Alarm path bypasses the comm-error force, as alarms are not MV outputs
   assign ctrl_out[1:0] = tp_on[1:0];
   assign ctrl_out[3:2] = two_ch_unit ? st_ff.alm : tp_on[3:2];
   assign pv = st_ff.y[cstpo_pkg::FILT_FRAC +: 16];
   assign pv_valid = st_ff.pv_vld;
   assign dp_digits = st_ff.dp;
   assign scale_hi = st_ff.hi;
   assign scale_lo = st_ff.lo;
   assign filt_tc = st_ff.tc;
   assign comm_err_seen = st_ff.err;
endmodule // cstpo_top
`default_nettype wire

// [verification/cstpo_checker.sv]
// Port assertions for the scaling and output block
`timescale 1ns/10ps
`default_nettype none
module cstpo_checker
#(
   parameter int RAW_W = 12
)
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic input_is_analog,
   input wire logic op_running,
   input wire logic signed [15:0] wr_data,
   input wire logic wr_scale_hi,
   input wire logic wr_dp,
   input wire logic [RAW_W-1:0] raw_in,
   input wire logic raw_valid,
   input wire logic signed [15:0] temp_in,
   input wire logic comm_err,
   input wire logic two_ch_unit,
   input wire logic [1:0] alarm1,
   input wire logic [3:0] ctrl_out,
   input wire logic signed [15:0] pv,
   input wire logic [1:0] dp_digits,
   input wire logic signed [15:0] scale_hi,
   input wire logic signed [15:0] scale_lo,
   input wire logic [13:0] filt_tc
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   sequence s_direct;
      raw_valid && input_is_analog && filt_tc == 14'h0000;
   endsequence
   a_hi_write: assert property (
      wr_scale_hi && !op_running && wr_data >= cstpo_pkg::SCALE_MIN
      && wr_data <= cstpo_pkg::SCALE_MAX |=> scale_hi == $past(wr_data))
      else $error("upper limit write lost");
   a_scale_hold: assert property (
      op_running |=> $stable(scale_hi) && $stable(scale_lo) && $stable(dp_digits))
      else $error("scaling changed while running");
   a_dp_write: assert property (
      wr_dp && !op_running |=> dp_digits == $past(wr_data[1:0]))
      else $error("decimal digits write lost");
   a_span_top: assert property (
      s_direct ##0 &raw_in |=> pv == $past(scale_hi > scale_lo ? scale_hi : scale_lo))
      else $error("span top not at upper limit");
   a_span_bottom: assert property (
      s_direct ##0 ~|raw_in |=> pv == $past(scale_hi > scale_lo ? scale_lo : scale_hi))
      else $error("span bottom not at lower limit");
   a_temp_pass: assert property (
      raw_valid && !input_is_analog && filt_tc == 14'h0000 |=> pv == $past(temp_in))
      else $error("temperature value altered");
   a_comm_off: assert property (
      comm_err [*5] |=> ctrl_out[1:0] == 2'h0 && ($past(two_ch_unit) || ctrl_out[3:2] == 2'h0))
      else $error("output on during comm error");
   a_alarm_follow: assert property (
      $past(nrst) && $past(two_ch_unit) && two_ch_unit |-> ctrl_out[3:2] == $past(alarm1))
      else $error("alarm outputs do not follow");
endmodule // cstpo_checker
bind cstpo_top cstpo_checker #(.RAW_W(RAW_W)) chk_u (.clock(clock), .nrst(nrst),
   .input_is_analog(input_is_analog), .op_running(op_running), .wr_data(wr_data),
   .wr_scale_hi(wr_scale_hi), .wr_dp(wr_dp), .raw_in(raw_in), .raw_valid(raw_valid),
   .temp_in(temp_in), .comm_err(comm_err), .two_ch_unit(two_ch_unit), .alarm1(alarm1),
   .ctrl_out(ctrl_out), .pv(pv), .dp_digits(dp_digits), .scale_hi(scale_hi),
   .scale_lo(scale_lo), .filt_tc(filt_tc));
`default_nettype wire

// [verification/cstpo_plant.sv]
// Heater relay and analog sensor stand-in
`timescale 1ns/10ps
`default_nettype none
module cstpo_plant
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic [3:0] relay,
   input wire logic clr,
   input wire logic smp,
   input wire logic [11:0] lvl,
   output logic [11:0] raw_in,
   output logic raw_valid,
   output logic [15:0] on_cnt
);
   always_ff @(posedge clock)
   begin
      raw_valid <= smp;
      // Stale code inverted each cycle so a read one cycle late never matches
      raw_in <= !nrst ? 12'h000 : (smp ? lvl : ~raw_in);
      if (!nrst || clr)
         on_cnt <= 16'h0000;
      else if (relay[0])
         on_cnt <= on_cnt + 16'h0001;
   end
endmodule // cstpo_plant
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for the scaling and output block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic clock, nrst, ana, run, clr, smp, comm, two, rv, pvv, ces;
   logic [4:0] ws;
   logic [15:0] wd, temp, on_cnt, pv, hi, lo;
   logic [11:0] lvl, raw;
   logic [9:0] mv;
   logic [1:0] alm, dp;
   logic [3:0] outs;
   logic [13:0] tc;
   int err_total, compares, cyc, pc;
   int per[4] = '{2, 0, 20, 0};
   int mvs[4] = '{300, 300, 250, 1000};
   // Short tick keeps a 20 s period near 4000 cycles
   cstpo_top #(.TICK_CYC(2)) dut_u (.clock(clock), .nrst(nrst), .input_is_analog(ana),
      .op_running(run), .wr_data(wd), .wr_scale_hi(ws[0]), .wr_scale_lo(ws[1]), .wr_dp(ws[2]),
      .wr_filt_tc(ws[3]), .wr_period({4{ws[4]}}), .raw_in(raw), .raw_valid(rv),
      .temp_in(temp), .mv(mv), .comm_err(comm), .two_ch_unit(two), .alarm1(alm),
      .ctrl_out(outs), .pv(pv), .pv_valid(pvv), .dp_digits(dp), .scale_hi(hi),
      .scale_lo(lo), .filt_tc(tc), .comm_err_seen(ces));
   cstpo_plant plant_u (.clock(clock), .nrst(nrst), .relay(outs), .clr(clr), .smp(smp),
      .lvl(lvl), .raw_in(raw), .raw_valid(rv), .on_cnt(on_cnt));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] s, input logic [15:0] d);
      ws = s;
      wd = d;
      @(negedge clock);
      ws = 5'h00;
      @(negedge clock);
   endtask
   task automatic smp_at(input logic [11:0] l);
      lvl = l;
      smp = 1'b1;
      @(negedge clock);
      smp = 1'b0;
      @(negedge clock);
      chk({15'h0000, pvv}, 16'h0001);
      @(negedge clock);
      chk({15'h0000, pvv}, 16'h0000);
      @(negedge clock);
   endtask
   // First period settles, second is counted
   task automatic meas(input int p, input int e);
      repeat (p) @(negedge clock);
      clr = 1'b1;
      @(negedge clock);
      clr = 1'b0;
      repeat (p) @(negedge clock);
      chk(on_cnt, e[15:0]);
   endtask
   task automatic wrap_up;
      $display("errors %0d compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         err_total++;
         wrap_up();
      end
   end
   initial
   begin
      {nrst, ana, run, clr, smp, comm, two, ws, wd, temp, lvl, mv, alm} = '0;
      repeat (3) @(negedge clock);
      nrst = 1'b1;
      chk(hi, 16'h03e8);
      chk(lo, 16'h0000);
      chk({14'h0000, dp}, 16'h0001);
      chk({2'h0, tc}, 16'h0000);
      ana = 1'b1;
      wr(5'h01, 16'h03b6);
      wr(5'h02, 16'h0064);
      wr(5'h04, 16'h0002);
      chk(hi, 16'h03b6);
      chk(lo, 16'h0064);
      chk({14'h0000, dp}, 16'h0002);
      smp_at(12'hfff);
      chk(pv, 16'h03b6);
      smp_at(12'h000);
      chk(pv, 16'h0064);
      wr(5'h01, 16'h2710);
      chk(hi, 16'h03b6);
      wr(5'h02, 16'h03e8);
      smp_at(12'hfff);
      chk(pv, 16'h03e8);
      run = 1'b1;
      wr(5'h07, 16'h0000);
      chk(hi, 16'h03b6);
      chk(lo, 16'h03e8);
      chk({14'h0000, dp}, 16'h0002);
      ana = 1'b0;
      temp = 16'h00fa;
      smp_at(12'h000);
      chk(pv, 16'h00fa);
      ana = 1'b1;
      wr(5'h08, 16'h000a);
      chk({2'h0, tc}, 16'h000a);
      smp_at(12'h000);
      // Lag must move part way only: above the old value, below the target
      chk({15'h0000, pv > 16'h00fa && pv < 16'h03b6}, 16'h0001);
      wr(5'h08, 16'h0000);
      smp_at(12'h000);
      chk(pv, 16'h03b6);
      run = 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         mv = mvs[i][9:0];
         if (i > 0)
            wr(5'h10, per[i][15:0]);
         pc = 2 * (per[i] == 0 ? 50 : per[i] * 100);
         meas(pc, pc * mvs[i] / 1000);
      end
      comm = 1'b1;
      meas(100, 0);
      chk({15'h0000, ces}, 16'h0001);
      comm = 1'b0;
      two = 1'b1;
      alm = 2'h2;
      repeat (2) @(negedge clock);
      chk({14'h0000, outs[3:2]}, 16'h0002);
      alm = 2'h1;
      // Sync needs four edges to let go of the error
      repeat (3) @(negedge clock);
      chk({14'h0000, outs[3:2]}, 16'h0001);
      chk({15'h0000, ces}, 16'h0000);
      wrap_up();
   end
endmodule // tb_top
`default_nettype wire
